/* File: inc/fenc_defs.svh */
/*
 front-end control constants: control word addresses, field positions,
 reset values. assumes inclusion by bare name from the package.
*/
`ifndef FENC_DEFS_SVH
`define FENC_DEFS_SVH
`define FENC_ADDR_INPUT_CFG 3'h0
`define FENC_ADDR_LVL_CFG 3'h1
`define FENC_ADDR_LVL_START 3'h2
`define FENC_ADDR_CTR_FREQ 3'h3
`define FENC_ADDR_FREQ_STROBE 3'h5
`define FENC_B_LOAD_ON_UPD 0
`define FENC_B_OFS_EN 1
`define FENC_B_CLR_ACC 2
`define FENC_B_SYNC_SEL 3
`define FENC_B_CIC_BYP 6
`define FENC_B_EXT_SYNC_EN 20
`define FENC_B_INT_MODE 30
`define FENC_IVL_HI 29
`define FENC_IVL_LO 14
`define FENC_THR_HI 13
`define FENC_RST_WORD 32'h0000_0000
`define FENC_OFS_BITS 32
`endif

/* File: inc/fenc_pkg.sv */
/*
 types for the front-end control block.
 assumes fenc_defs.svh is on the include path.
*/
package fenc_pkg;
`include "fenc_defs.svh"
   typedef enum logic [0:0] {
      FENC_LVL_IDLE = 1'b0,
      FENC_LVL_RUN = 1'b1
   } fenc_lvl_st_t;
   typedef struct packed {
      logic [31:0] in_cfg;
      logic [31:0] lvl_cfg;
      logic [31:0] freq_hold;
      logic [31:0] freq_act;
      logic [31:0] phase_acc;
      logic [31:0] ofs_shift;
      logic [31:0] ofs_word;
      logic load_pend;
      fenc_lvl_st_t lvl_st;
      logic [17:0] ivl_cnt;
      logic [31:0] integ;
      logic [31:0] lvl_result;
      logic [23:0] cic_out;
      logic sync_out;
   } fenc_state_t;
endpackage : fenc_pkg

/* File: src/fenc_top.sv */
/*
 front-end control of a downconverter: cic bypass, nco control, level
 detector. assumes host writes are synchronous to clk_sys_i and single
 cycle; clk_sys_i stands for the input sample clock.
*/
`timescale 1ns/1ps
module fenc_top
   import fenc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic wr_en_i,
   input wire logic [2:0] wr_addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic input_enable_n_i,
   input wire logic [13:0] sample_i,
   input wire logic [38:0] shifter_i,
   input wire logic [23:0] cic_filt_i,
   input wire logic front_end_sync_in_i,
   input wire logic proc_sync_i,
   input wire logic offset_freq_serial_data_i,
   input wire logic offset_freq_serial_frame_i,
   output logic [23:0] cic_out_o,
   output logic sync_out_o,
   output logic [31:0] phase_o,
   output logic [31:0] freq_act_o,
   output logic [31:0] level_result_o,
   output logic level_busy_o
);
   fenc_state_t s_q;
   fenc_state_t s_d;

   // magnitude of a 14-bit two's complement sample, 14 magnitude bits so -8192 gives 8192
   function automatic logic [13:0] mag14(input logic [13:0] x);
      mag14 = x[13] ? 14'(-x) : x;
   endfunction : mag14

   function automatic logic [31:0] sext14(input logic [13:0] x);
      sext14 = {{18{x[13]}}, x};
   endfunction : sext14

   logic wr_cfg0, wr_cfg1, wr_start, wr_freq, wr_strobe;
   logic upd_now, do_load, fb_zero;
   logic [31:0] step;
   logic [17:0] preload;
   logic [31:0] lvl_add;

   // decode writes
   assign wr_cfg0 = wr_en_i && (wr_addr_i == `FENC_ADDR_INPUT_CFG);
   assign wr_cfg1 = wr_en_i && (wr_addr_i == `FENC_ADDR_LVL_CFG);
   assign wr_start = wr_en_i && (wr_addr_i == `FENC_ADDR_LVL_START);
   assign wr_freq = wr_en_i && (wr_addr_i == `FENC_ADDR_CTR_FREQ);
   assign wr_strobe = wr_en_i && (wr_addr_i == `FENC_ADDR_FREQ_STROBE);
   // updates only take effect on enabled cycles
   assign upd_now = !input_enable_n_i;
   assign do_load = upd_now && (s_q.load_pend || wr_strobe);
   assign fb_zero = s_q.in_cfg[`FENC_B_CLR_ACC] ||
      (do_load && s_q.in_cfg[`FENC_B_LOAD_ON_UPD]);
   assign step = s_q.freq_act + (s_q.in_cfg[`FENC_B_OFS_EN] ?
      s_q.ofs_word : 32'h0000_0000);
   // low two preload bits fixed at 01 so the count is 4n plus 1
   assign preload = {s_q.lvl_cfg[`FENC_IVL_HI:`FENC_IVL_LO], 2'b01};
   // magnitude is unsigned, zero-extended; only the threshold is signed
   assign lvl_add = {18'h0_0000, mag14(sample_i)} +
      sext14(s_q.lvl_cfg[`FENC_THR_HI:0]);

   // next-state logic for everything
   always_comb begin
      s_d = s_q;
      if (wr_cfg0) begin
         s_d.in_cfg = wr_data_i;
      end
      if (wr_cfg1) begin
         s_d.lvl_cfg = wr_data_i;
      end
      if (wr_freq) begin
         s_d.freq_hold = wr_data_i;
      end
      // pending load: set wins over the clear by the load itself
      if (do_load) begin
         s_d.load_pend = 1'b0;
      end
      if (front_end_sync_in_i && s_q.in_cfg[`FENC_B_EXT_SYNC_EN]) begin
         s_d.load_pend = 1'b1;
      end
      if (do_load) begin
         s_d.freq_act = s_q.freq_hold;
      end
      // 32-bit accumulator wraps, covering +/- half rate
      if (upd_now) begin
         s_d.phase_acc = (fb_zero ? 32'h0000_0000 : s_q.phase_acc)
            + step;
      end
      // serial offset word, msb first, framed by the frame pin
      if (offset_freq_serial_frame_i) begin
         s_d.ofs_shift = {31'h0000_0000, offset_freq_serial_data_i};
         s_d.ofs_word = s_q.ofs_shift;
      end else begin
         s_d.ofs_shift = {s_q.ofs_shift[30:0], offset_freq_serial_data_i};
      end
      // bypass keeps low 24 shifter bits; source guarantees rate
      s_d.cic_out = s_q.in_cfg[`FENC_B_CIC_BYP] ? shifter_i[23:0]
         : cic_filt_i;
      s_d.sync_out = s_q.in_cfg[`FENC_B_SYNC_SEL] ? proc_sync_i
         : front_end_sync_in_i;
      // level detector, runs every clock regardless of enable
      case (s_q.lvl_st)
         FENC_LVL_IDLE: begin
         end
         FENC_LVL_RUN: begin
            s_d.integ = s_q.integ + lvl_add;
            if (s_q.ivl_cnt <= 18'h0_0001) begin
               if (s_q.lvl_cfg[`FENC_B_INT_MODE]) begin
                  s_d.lvl_result = s_d.integ;
                  s_d.integ = 32'h0000_0000;
                  s_d.ivl_cnt = preload;
               end else begin
                  s_d.lvl_result = s_d.integ;
                  s_d.lvl_st = FENC_LVL_IDLE;
               end
            end else begin
               s_d.ivl_cnt = s_q.ivl_cnt - 18'h0_0001;
            end
         end
         default: begin
            s_d.lvl_st = FENC_LVL_IDLE;
         end
      endcase
      if (wr_start) begin
         s_d.lvl_st = FENC_LVL_RUN;
         s_d.integ = 32'h0000_0000;
         s_d.ivl_cnt = preload;
      end
   end

   // single state register
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cic_out_o = s_q.cic_out;
   assign sync_out_o = s_q.sync_out;
   assign phase_o = s_q.phase_acc;
   assign freq_act_o = s_q.freq_act;
   assign level_result_o = s_q.lvl_result;
   assign level_busy_o = (s_q.lvl_st == FENC_LVL_RUN);

   // cic and sync outputs follow their selects one cycle later
   chk_bypass_path: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_q.in_cfg[`FENC_B_CIC_BYP]
      |=> cic_out_o == $past(shifter_i[23:0]))
      else $error("bypass output wrong");
   chk_filter_path: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !s_q.in_cfg[`FENC_B_CIC_BYP]
      |=> cic_out_o == $past(cic_filt_i))
      else $error("filtered output wrong");
   chk_sync_sel: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      s_q.in_cfg[`FENC_B_SYNC_SEL]
      |=> sync_out_o == $past(proc_sync_i))
      else $error("sync source wrong");
   chk_sync_direct: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !s_q.in_cfg[`FENC_B_SYNC_SEL]
      |=> sync_out_o == $past(front_end_sync_in_i))
      else $error("direct sync source wrong");

   // accumulator: clear and load-on-update both restart from the step
   chk_clear_acc: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (s_q.in_cfg[`FENC_B_CLR_ACC] && !input_enable_n_i)
      |=> phase_o == $past(step))
      else $error("clear failed");
   chk_load_zero: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (do_load && s_q.in_cfg[`FENC_B_LOAD_ON_UPD])
      |=> phase_o == $past(step))
      else $error("load did not zero feedback");
   chk_nco_run: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (!input_enable_n_i && !fb_zero)
      |=> phase_o == $past(phase_o) + $past(step))
      else $error("accumulator step wrong");
   chk_nco_hold: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      input_enable_n_i
      |=> $stable(phase_o) && $stable(freq_act_o))
      else $error("nco moved while disabled");

   // serial offset word only changes at a frame mark
   chk_ofs_frame: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      offset_freq_serial_frame_i
      |=> s_q.ofs_word == $past(s_q.ofs_shift))
      else $error("offset word not taken");
   chk_ofs_keep: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !offset_freq_serial_frame_i
      |=> $stable(s_q.ofs_word))
      else $error("offset word moved");
   chk_ofs_off: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !s_q.in_cfg[`FENC_B_OFS_EN]
      |-> step == freq_act_o)
      else $error("offset added while off");

   // frequency moves from holding to active register only on a load
   chk_hold_write: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_freq
      |=> s_q.freq_hold == $past(wr_data_i))
      else $error("holding word not written");
   chk_held_active: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      !do_load
      |=> $stable(freq_act_o))
      else $error("active word moved without load");
   chk_strobe_load: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (wr_strobe && !input_enable_n_i)
      |=> freq_act_o == $past(s_q.freq_hold))
      else $error("strobe lost");
   chk_sync_pend: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (front_end_sync_in_i && s_q.in_cfg[`FENC_B_EXT_SYNC_EN])
      |=> s_q.load_pend)
      else $error("sync not held");
   chk_pend_clear: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (do_load && !(front_end_sync_in_i &&
      s_q.in_cfg[`FENC_B_EXT_SYNC_EN])) |=> !s_q.load_pend)
      else $error("pending load not cleared");
   chk_sync_load: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (s_q.load_pend && !input_enable_n_i)
      |=> freq_act_o == $past(s_q.freq_hold))
      else $error("pending sync load lost");

   // level detector start, count and add
   chk_start_run: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_start
      |=> level_busy_o && s_q.integ == 32'h0000_0000)
      else $error("start ignored");
   chk_preload_val: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_start |=> s_q.ivl_cnt[1:0] == 2'b01 &&
      s_q.ivl_cnt[17:2] == $past(s_q.lvl_cfg[`FENC_IVL_HI:`FENC_IVL_LO]))
      else $error("interval preload wrong");
   chk_integ_add: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (level_busy_o && s_q.ivl_cnt > 18'h0_0001 && !wr_start)
      |=> s_q.integ == $past(s_q.integ) + $past(lvl_add))
      else $error("integrator add wrong");
   chk_ivl_count: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (level_busy_o && s_q.ivl_cnt > 18'h0_0001 && !wr_start)
      |=> s_q.ivl_cnt == $past(s_q.ivl_cnt) - 18'h0_0001)
      else $error("interval count wrong");

   // level detector timeout in both modes
   chk_result_latch: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (level_busy_o && s_q.ivl_cnt <= 18'h0_0001 && !wr_start)
      |=> level_result_o == $past(s_q.integ) + $past(lvl_add))
      else $error("result not latched");
   chk_mode0_stop: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (level_busy_o && !s_q.lvl_cfg[`FENC_B_INT_MODE] &&
      s_q.ivl_cnt <= 18'h0_0001 && !wr_start) |=> !level_busy_o)
      else $error("no stop");
   chk_mode1_reload: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (level_busy_o && s_q.lvl_cfg[`FENC_B_INT_MODE] &&
      s_q.ivl_cnt <= 18'h0_0001 && !wr_start)
      |=> level_busy_o && s_q.ivl_cnt == $past(preload))
      else $error("no reload");
   chk_idle_hold: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      (!level_busy_o && !wr_start)
      |=> !level_busy_o && $stable(level_result_o))
      else $error("idle detector moved");
endmodule : fenc_top

/* File: bench/fenc_ofs_src.sv */
/*
 serial offset word source standing in for the far side.
 assumes the bench clock and a go pulse set just after an edge.
*/
`timescale 1ns/1ps
module fenc_ofs_src (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [31:0] word_i,
   output logic data_o,
   output logic frame_o
);
   // msb first, frame high in the cycle after the last bit
   initial begin
      data_o = 1'b0;
      frame_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i) begin
            for (int i = 31; i >= 0; i--) begin
               #1 data_o = word_i[i];
               @(posedge clk_i);
            end
            #1 frame_o = 1'b1;
            data_o = ~data_o; // no pull: show inverse of last bit
            @(posedge clk_i);
            #1 frame_o = 1'b0;
         end
      end
   end
endmodule : fenc_ofs_src

/* File: bench/tb.sv */
/*
 self-checking bench for the front-end control block.
 assumes single-cycle host writes and 1 ns drive skew after each edge.
*/
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, en_n = 1'b1;
   logic fe_sync = 1'b0, p_sync = 1'b0, go = 1'b0, ofs_d, ofs_f;
   logic [2:0] addr = 3'h0;
   logic [31:0] data = 32'h0000_0000, word = 32'h0000_0000, p;
   logic [13:0] sample = 14'h0000;
   logic [38:0] shifter = 39'h00_0000_0000;
   logic [23:0] cic_filt = 24'h00_0000, cic_out;
   logic [31:0] phase, freq_act, result;
   logic sync_out, busy;
   int bad_count = 0;
   int n_tests = 0;
   always #2 clk = ~clk;
   fenc_top i_dut (.clk_sys_i(clk), .reset_i(rst), .wr_en_i(wr_en),
      .wr_addr_i(addr), .wr_data_i(data), .input_enable_n_i(en_n),
      .sample_i(sample), .shifter_i(shifter), .cic_filt_i(cic_filt),
      .front_end_sync_in_i(fe_sync), .proc_sync_i(p_sync),
      .offset_freq_serial_data_i(ofs_d),
      .offset_freq_serial_frame_i(ofs_f), .cic_out_o(cic_out),
      .sync_out_o(sync_out), .phase_o(phase), .freq_act_o(freq_act),
      .level_result_o(result), .level_busy_o(busy));
   fenc_ofs_src i_src (.clk_i(clk), .go_i(go), .word_i(word),
      .data_o(ofs_d), .frame_o(ofs_f));
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // extra idle edge keeps wr_en from being set twice in one step
   task wr(input logic [2:0] a, input logic [31:0] d);
      wr_en = 1'b1;
      addr = a;
      data = d;
      tick(1);
      wr_en = 1'b0;
      tick(1);
   endtask : wr
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task results;
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   task t_strobe;
      en_n = 1'b0;
      wr(3'h3, 32'h1234_5678);
      chk(freq_act, 32'h0000_0000);
      en_n = 1'b1;
      wr(3'h5, 32'h0000_0000);
      chk(freq_act, 32'h0000_0000);
      en_n = 1'b0;
      wr(3'h5, 32'h0000_0000);
      chk(freq_act, 32'h1234_5678);
   endtask : t_strobe
   // second sync with equal word makes the zeroed phase unambiguous
   task t_sync;
      en_n = 1'b1;
      wr(3'h0, 32'h0010_0001);
      wr(3'h3, 32'h0000_0100);
      for (int k = 0; k < 2; k++) begin
         fe_sync = 1'b1;
         tick(1);
         fe_sync = 1'b0;
         tick(2);
         if (k == 0) chk(freq_act, 32'h1234_5678);
         en_n = 1'b0;
         tick(1);
         chk(freq_act, 32'h0000_0100);
         if (k == 1) chk(phase, 32'h0000_0100);
         tick(3);
         en_n = 1'b1;
      end
      en_n = 1'b0;
      p = phase;
      tick(1);
      chk(phase - p, 32'h0000_0100);
   endtask : t_sync
   task t_front;
      shifter = 39'h12_3456_789A;
      cic_filt = 24'hAB_CDEF;
      p_sync = 1'b1;
      tick(2);
      chk(cic_out, 32'h00AB_CDEF);
      wr(3'h0, 32'h0000_0048);
      chk(cic_out, 32'h0056_789A);
      chk(sync_out, 32'h1);
      // source toggles enable in bypass so clock is twice the rate
      p_sync = 1'b0;
      fe_sync = 1'b1;
      en_n = 1'b1;
      p = phase;
      tick(1);
      chk(sync_out, 32'h0);
      chk(phase, p);
      fe_sync = 1'b0;
      en_n = 1'b0;
   endtask : t_front
   // |-100| plus threshold -10 over preload 5 gives 450
   task t_level;
      sample = 14'h3F9C;
      wr(3'h1, 32'h0000_7FF6);
      wr(3'h2, 32'hDEAD_BEEF);
      for (int i = 0; i < 40 && busy !== 1'b0; i++) tick(1);
      if (busy !== 1'b0) begin
         bad_count++;
      end else begin
         tick(3);
         chk(result, 32'h0000_01C2);
         chk(busy, 32'h0);
         // |-200| - 10 over 5 cycles with enable off gives 950
         sample = 14'h3F38;
         en_n = 1'b1;
         wr(3'h1, 32'h4000_7FF6);
         wr(3'h2, 32'h0000_0000);
         tick(12);
         chk(result, 32'h0000_03B6);
         chk(busy, 32'h1);
      end
   endtask : t_level
   task t_offset;
      en_n = 1'b0;
      wr(3'h0, 32'h0000_0002);
      word = 32'h0001_0000;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(36);
      p = phase;
      tick(1);
      chk(phase - p, 32'h0001_0100);
      // clear bit: feedback zero, phase sits at the step each cycle
      wr(3'h0, 32'h0000_0006);
      chk(phase, 32'h0001_0100);
      tick(1);
      chk(phase, 32'h0001_0100);
   endtask : t_offset
   initial begin
      tick(4);
      rst = 1'b0;
      t_strobe();
      t_sync();
      t_front();
      t_level();
      t_offset();
      results();
   end
endmodule : tb
